/* rtl/plcu_top.sv */
`timescale 1ns/1ps
`include "plcu_map.svh"
module plcu_top #(
  parameter int LANES = 4,
  parameter logic [15:0] TO_SHORT = `PLCU_TO_SHORT,
  parameter logic [15:0] TO_LONG = `PLCU_TO_LONG
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic [31:0] tx_in_dat,
  input wire logic tx_in_ctrl,
  input wire logic tx_in_start,
  output logic tx_in_ready,
  output logic [31:0] tx_command_address_data_lines,
  output logic tx_link_control_line,
  input wire logic [31:0] rx_command_address_data_lines,
  input wire logic rx_link_control_line,
  input wire logic rx_start,
  output logic [31:0] rx_out_dat,
  output logic rx_out_ctrl,
  output logic rx_out_vld,
  output logic rx_commit,
  input wire logic link_reset_pin_n,
  input wire logic first_generation_protocol,
  input wire logic control_deassert_timeout_long,
  input wire logic enter_reset,
  input wire logic warm_rst,
  input wire logic map_flood,
  input wire logic map_fatal,
  input wire logic map_nonfatal,
  input wire logic [3:0] link_control_register_crc_clr,
  input wire logic proto_err_clr,
  output logic [3:0] link_control_register_crc_err,
  output logic proto_err_log,
  output logic ovf_err_log,
  output logic sync_flood_req,
  output logic fatal_irq,
  output logic nonfatal_irq
);
  // -------------------------------------------------------------------
  // elaboration checks and lane masks
  // -------------------------------------------------------------------
  if (!(LANES inside {1, 2, 4})) begin : g_bad_lanes
    $error("LANES must be 1, 2 or 4");
  end
  if (TO_SHORT == 16'h0000 || TO_LONG == 16'h0000) begin : g_bad_to
    $error("timeouts must be nonzero");
  end

  localparam logic [3:0] LMASK = (LANES == 4) ? 4'hf :
                                 (LANES == 2) ? 4'h3 : 4'h1;
  localparam logic [31:0] DMASK = (LANES == 4) ? 32'hffffffff :
                                  (LANES == 2) ? 32'h0000ffff :
                                  32'h000000ff;

  // -------------------------------------------------------------------
  // crossings
  // -------------------------------------------------------------------
  logic [2:0] cfg_s;
  logic lrst_s;
  logic [4:0] evt_s;
  plcu_pkg::plcu_link_type lk_q;
  plcu_pkg::plcu_link_type lk_d;
  plcu_pkg::plcu_core_type cr_q;
  plcu_pkg::plcu_core_type cr_d;

  // quasi-static levels from the core side into the link domain
  plcu_sync #(.W(3), .RST(3'h0)) u_cfg (
    .clk(link_clk),
    .arst_n(arst_n),
    .d({enter_reset, control_deassert_timeout_long,
        first_generation_protocol}),
    .q(cfg_s)
  );

  plcu_sync #(.W(1), .RST(1'h1)) u_pin (
    .clk(link_clk),
    .arst_n(arst_n),
    .d(link_reset_pin_n),
    .q(lrst_s)
  );

  // error events cross as toggles, one bit per event source
  plcu_sync #(.W(5), .RST(5'h00)) u_evt (
    .clk(core_clk),
    .arst_n(arst_n),
    .d({lk_q.ptgl, lk_q.ctgl}),
    .q(evt_s)
  );

  wire fgp_s = cfg_s[0];
  wire tol_s = cfg_s[1];
  wire ent_s = cfg_s[2];

  // -------------------------------------------------------------------
  // link domain
  // -------------------------------------------------------------------
  wire [31:0] rxd = rx_command_address_data_lines;
  wire rxc = rx_link_control_line;
  wire tslot = plcu_pkg::plcu_slot(lk_q.tw, lk_q.tpos);
  wire tlast = plcu_pkg::plcu_last(lk_q.tw, lk_q.tpos);
  wire rslot = plcu_pkg::plcu_slot(lk_q.rw, lk_q.rpos);
  wire rlast = plcu_pkg::plcu_last(lk_q.rw, lk_q.rpos);
  wire [31:0] rexp = plcu_pkg::plcu_crc_byte(lk_q.rprev, lk_q.rpos);
  wire flood = rxc && ((rxd | ~DMASK) == 32'hffffffff);
  wire [15:0] to_lim = tol_s ? TO_LONG : TO_SHORT;
  logic [3:0] mism;
  plcu_pkg::plcu_crc4_type tnew;
  plcu_pkg::plcu_crc4_type rnew;

  always_comb begin
    lk_d = lk_q;
    mism = '0;
    for (int l = 0; l < 4; l++) begin
      mism[l] = LMASK[l] && (rxd[8*l+:8] != rexp[8*l+:8]);
    end
    // ---- transmit: window walk and crc insertion ----
    tnew = plcu_pkg::plcu_absorb(lk_q.tcrc, tx_in_dat, tx_in_ctrl);
    if (tslot) begin
      lk_d.tdat = plcu_pkg::plcu_crc_byte(lk_q.tprev, lk_q.tpos);
      lk_d.tcl = 1'b1;
    end else begin
      lk_d.tdat = tx_in_dat;
      lk_d.tcl = tx_in_ctrl;
    end
    unique case (lk_q.tw)
      plcu_pkg::WIN_IDLE: begin
        if (tx_in_start) begin
          lk_d.tw = plcu_pkg::WIN_FIRST;
          lk_d.tpos = 10'h001;
          lk_d.tcrc = plcu_pkg::plcu_absorb({4{`PLCU_SEED}}, tx_in_dat,
                                            tx_in_ctrl);
        end
      end
      plcu_pkg::WIN_FIRST, plcu_pkg::WIN_LATER: begin
        if (!tslot) begin
          lk_d.tcrc = tnew;
        end
        if (tlast) begin
          lk_d.tprev = tnew;
          lk_d.tcrc = {4{`PLCU_SEED}};
          lk_d.tpos = 10'h000;
          lk_d.tw = plcu_pkg::WIN_LATER;
        end else begin
          lk_d.tpos = lk_q.tpos + 10'h001;
        end
      end
    endcase
    if (ent_s) begin
      lk_d.tw = plcu_pkg::WIN_IDLE;
      lk_d.tdat = 32'hffffffff;
      lk_d.tcl = 1'b0;
    end
    // source stalls through the crc bit-times
    lk_d.trdy = !ent_s && !plcu_pkg::plcu_slot(lk_d.tw, lk_d.tpos);

    // ---- receive: window walk and crc check ----
    rnew = plcu_pkg::plcu_absorb(lk_q.rcrc, rxd, rxc);
    lk_d.rdat = rxd;
    lk_d.rcl = rxc;
    lk_d.rvld = !rslot;
    lk_d.rcommit = 1'b0;
    unique case (lk_q.rw)
      plcu_pkg::WIN_IDLE: begin
        if (rx_start) begin
          lk_d.rw = plcu_pkg::WIN_FIRST;
          lk_d.rpos = 10'h001;
          lk_d.rcrc = plcu_pkg::plcu_absorb({4{`PLCU_SEED}}, rxd, rxc);
        end
      end
      plcu_pkg::WIN_FIRST, plcu_pkg::WIN_LATER: begin
        if (!rslot) begin
          lk_d.rcrc = rnew;
        end else begin
          lk_d.rbad = lk_q.rbad | mism;
        end
        if (rlast) begin
          lk_d.rprev = rnew;
          lk_d.rcrc = {4{`PLCU_SEED}};
          lk_d.rpos = 10'h000;
          lk_d.rw = plcu_pkg::WIN_LATER;
        end else begin
          lk_d.rpos = lk_q.rpos + 10'h001;
        end
      end
    endcase
    // data is held uncommitted until a later control bit-time
    if (!rslot && lk_q.rw != plcu_pkg::WIN_IDLE) begin
      if (!rxc) begin
        lk_d.rdpend = 1'b1;
      end else begin
        lk_d.rdpend = 1'b0;
        lk_d.rcommit = lk_q.rdpend;
      end
    end

    // ---- error hold-off, deferral and release ----
    if (lk_q.pcnt != 5'h00) begin
      if (flood) begin
        lk_d.pend = 4'h0;
        lk_d.pcnt = 5'h00;
      end else begin
        lk_d.pcnt = lk_q.pcnt - 5'h01;
      end
    end else if (lk_q.pend != 4'h0) begin
      if (!lrst_s) begin
        lk_d.pend = 4'h0;
      end else if (!(fgp_s && !rxc)) begin
        lk_d.ctgl = lk_q.ctgl ^ lk_q.pend;
        lk_d.pend = 4'h0;
      end
    end
    if (rslot && lk_q.rpos == `PLCU_SLOT_AT + `PLCU_SLOT_LEN - 10'h001)
    begin
      lk_d.pend = lk_d.pend | lk_q.rbad | mism;
      lk_d.pcnt = `PLCU_FLOOD_WAIT;
      lk_d.rbad = 4'h0;
    end

    // ---- control-deassert timeout ----
    if (lk_q.rw == plcu_pkg::WIN_IDLE || rxc) begin
      lk_d.tocnt = 16'h0000;
      lk_d.todone = 1'b0;
    end else if (lk_q.tocnt != to_lim) begin
      lk_d.tocnt = lk_q.tocnt + 16'h0001;
    end else if (!lk_q.todone) begin
      lk_d.ptgl = ~lk_q.ptgl;
      lk_d.todone = 1'b1;
    end
    if (!lrst_s) begin
      lk_d.rw = plcu_pkg::WIN_IDLE;
      lk_d.rbad = 4'h0;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign tx_in_ready = lk_q.trdy;
  assign tx_command_address_data_lines = lk_q.tdat;
  assign tx_link_control_line = lk_q.tcl;
  assign rx_out_dat = lk_q.rdat;
  assign rx_out_ctrl = lk_q.rcl;
  assign rx_out_vld = lk_q.rvld;
  assign rx_commit = lk_q.rcommit;

  // -------------------------------------------------------------------
  // core domain: error logs and reporting
  // -------------------------------------------------------------------
  logic [3:0] cev;
  logic pev;

  always_comb begin
    cr_d = cr_q;
    cev = (evt_s[3:0] ^ cr_q.cseen) & LMASK;
    pev = evt_s[4] ^ cr_q.pseen;
    cr_d.cseen = evt_s[3:0];
    cr_d.pseen = evt_s[4];
    // set wins over a write-one clear in the same cycle
    cr_d.clog = ((cr_q.clog & ~link_control_register_crc_clr) | cev)
                & LMASK;
    cr_d.plog = (cr_q.plog & ~proto_err_clr) | pev;
    cr_d.ovf = 1'b0;
    // warm reset silences reporting but leaves the logs alone
    cr_d.flood = !warm_rst && map_flood && (|cr_d.clog || cr_d.plog);
    cr_d.fatal = !warm_rst && map_fatal && (|cr_d.clog || cr_d.plog);
    cr_d.nonfatal = !warm_rst && map_nonfatal &&
                    (|cr_d.clog || cr_d.plog);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cr_q <= '0;
    end else begin
      cr_q <= cr_d;
    end
  end

  assign link_control_register_crc_err = cr_q.clog;
  assign proto_err_log = cr_q.plog;
  assign ovf_err_log = cr_q.ovf;
  assign sync_flood_req = cr_q.flood;
  assign fatal_irq = cr_q.fatal;
  assign nonfatal_irq = cr_q.nonfatal;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  sequence s_slot_start;
    tslot && lk_q.tpos == `PLCU_SLOT_AT && !ent_s;
  endsequence

  tx_slot_ctrl_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    s_slot_start |=> tx_link_control_line [*4])
    else $error("control line not high over crc bit-times");

  tx_stall_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    tslot |-> !tx_in_ready)
    else $error("source not stalled in crc slot");

  tx_crc_byte_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    s_slot_start |=> tx_command_address_data_lines[7:0] ==
                     ~$past(lk_q.tprev[0][7:0]))
    else $error("first crc byte not inverted low byte");

  win_seed_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    tlast && !ent_s |=> lk_q.tpos == 10'h000 &&
      lk_q.tw == plcu_pkg::WIN_LATER && lk_q.tcrc == {4{`PLCU_SEED}})
    else $error("window did not restart seeded");

  first_win_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    lk_q.tw == plcu_pkg::WIN_FIRST |-> !tslot)
    else $error("crc sent in first window");

  reset_sig_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    ent_s |=> !tx_link_control_line &&
              tx_command_address_data_lines == 32'hffffffff)
    else $error("reset signalling not driven");

  err_hold_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    lk_q.ctgl != $past(lk_q.ctgl) |-> $past(lk_q.pcnt) == 5'h00)
    else $error("crc error released during hold-off");

  defer_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    fgp_s && !rxc && lk_q.pcnt == 5'h00 |=> $stable(lk_q.ctgl))
    else $error("error not deferred while control low");

  timeout_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    lk_q.rw != plcu_pkg::WIN_IDLE && !rxc && lk_q.tocnt == to_lim &&
    !lk_q.todone |=> lk_q.ptgl != $past(lk_q.ptgl))
    else $error("timeout did not raise protocol error");

  log_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    cev[2] |=> link_control_register_crc_err[2] [*2])
    else $error("lane 2 crc error not logged and held");

  log_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    proto_err_clr && !pev |=> !proto_err_log)
    else $error("write-one clear ignored");
endmodule : plcu_top

/* rtl/plcu_map.svh */
`ifndef PLCU_MAP_SVH
`define PLCU_MAP_SVH
// ---------------------------------------------------------------------
// crc arithmetic
// ---------------------------------------------------------------------
`define PLCU_POLY 32'h04c11db7
`define PLCU_SEED 32'hffffffff
// ---------------------------------------------------------------------
// window layout, in bit-times
// ---------------------------------------------------------------------
`define PLCU_WIN_LEN 10'h200
`define PLCU_SLOT_AT 10'h040
`define PLCU_SLOT_LEN 10'h004
`define PLCU_FLOOD_WAIT 5'h10
// ---------------------------------------------------------------------
// control-deassert timeout defaults, in bit-times
// ---------------------------------------------------------------------
`define PLCU_TO_SHORT 16'h0400
`define PLCU_TO_LONG 16'hffff
`endif

/* rtl/plcu_pkg.sv */
`include "plcu_map.svh"
package plcu_pkg;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {WIN_IDLE, WIN_FIRST, WIN_LATER} plcu_win_type;
  typedef logic [3:0][31:0] plcu_crc4_type;

  typedef struct packed {
    plcu_win_type tw;
    logic [9:0] tpos;
    plcu_crc4_type tcrc;
    plcu_crc4_type tprev;
    logic [31:0] tdat;
    logic tcl;
    logic trdy;
    plcu_win_type rw;
    logic [9:0] rpos;
    plcu_crc4_type rcrc;
    plcu_crc4_type rprev;
    logic [3:0] rbad;
    logic [3:0] pend;
    logic [4:0] pcnt;
    logic [15:0] tocnt;
    logic todone;
    logic [3:0] ctgl;
    logic ptgl;
    logic [31:0] rdat;
    logic rcl;
    logic rvld;
    logic rdpend;
    logic rcommit;
  } plcu_link_type;

  typedef struct packed {
    logic [3:0] cseen;
    logic pseen;
    logic [3:0] clog;
    logic plog;
    logic ovf;
    logic flood;
    logic fatal;
    logic nonfatal;
  } plcu_core_type;

  // -------------------------------------------------------------------
  // crc and window helpers
  // -------------------------------------------------------------------
  function automatic logic [31:0] plcu_crc9(logic [31:0] c, logic [8:0] m);
    logic t;
    for (int i = 0; i < 9; i++) begin
      t = c[31];
      c = {c[30:0], m[i]};
      if (t) begin
        c = c ^ `PLCU_POLY;
      end
    end
    return c;
  endfunction : plcu_crc9

  // sublink 0 carries the real control line, the others a data zero
  function automatic plcu_crc4_type plcu_absorb(plcu_crc4_type c,
                                                logic [31:0] dl, logic cl);
    for (int l = 0; l < 4; l++) begin
      c[l] = plcu_crc9(c[l], {(l == 0) ? cl : 1'b0, dl[8*l+:8]});
    end
    return c;
  endfunction : plcu_absorb

  function automatic logic plcu_slot(plcu_win_type w, logic [9:0] p);
    return w == WIN_LATER && p >= `PLCU_SLOT_AT &&
           p < `PLCU_SLOT_AT + `PLCU_SLOT_LEN;
  endfunction : plcu_slot

  function automatic logic plcu_last(plcu_win_type w, logic [9:0] p);
    return (w == WIN_FIRST && p == `PLCU_WIN_LEN - 10'h001) ||
           (w == WIN_LATER &&
            p == `PLCU_WIN_LEN + `PLCU_SLOT_LEN - 10'h001);
  endfunction : plcu_last

  // inverted crc byte k of every sublink, low byte first
  function automatic logic [31:0] plcu_crc_byte(plcu_crc4_type c,
                                                logic [9:0] p);
    logic [9:0] k;
    logic [31:0] r;
    k = p - `PLCU_SLOT_AT;
    for (int l = 0; l < 4; l++) begin
      r[8*l+:8] = ~c[l][8*k[1:0]+:8];
    end
    return r;
  endfunction : plcu_crc_byte
endpackage : plcu_pkg

/* rtl/plcu_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module plcu_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } plcu_sync_type;

  plcu_sync_type st_q;
  plcu_sync_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.o[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= {RST, RST, RST, RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.o;
endmodule : plcu_sync

/* tb/plcu_peer.sv */
`timescale 1ns/1ps
// far link end: returns our transmit pins after one wire stage
module plcu_peer (
  input wire logic link_clk,
  input wire logic arst_n,
  input wire logic [31:0] tx_cad,
  input wire logic tx_ctl,
  input wire logic tx_start,
  input wire logic [3:0] bad_lane,
  output logic [31:0] rx_cad,
  output logic rx_ctl,
  output logic rx_start
);
  logic start_q;
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
      rx_start <= 1'b0;
      rx_cad <= 32'h0;
      rx_ctl <= 1'b0;
    end else begin
      // start travels with the first bit-time through pin and wire
      start_q <= tx_start;
      rx_start <= start_q;
      // a set lane bit flips line 0 of that sublink only
      for (int l = 0; l < 4; l++) begin
        rx_cad[8*l+:8] <= tx_cad[8*l+:8] ^ {7'h0, bad_lane[l]};
      end
      rx_ctl <= tx_ctl;
    end
  end
endmodule : plcu_peer

/* tb/test_plcu_top.sv */
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %s", $time, m); end end
module test_plcu_top;
  logic core_clk = 0, link_clk = 0, arst_n = 0;
  logic [31:0] tx_in_dat = 32'h0, tx_cad, rx_cad, rx_out_dat;
  logic tx_in_ctrl = 1, tx_in_start = 0, tx_in_ready, tx_ctl, rx_ctl;
  logic rx_start, rx_out_ctrl, rx_out_vld, rx_commit, enter_reset = 0;
  logic warm_rst = 0, map_flood = 0, map_fatal = 0, map_nonfatal = 0;
  logic [3:0] crc_clr = 4'h0, crc_err, bad_lane = 4'h0;
  logic proto_clr = 0, proto_log, ovf_log, flood_req, fatal_irq, nf_irq;
  logic go = 0, run = 0, sl_pend = 0;
  logic [31:0] pat = 32'h3c5a9600, pcad = 32'h0;
  logic pctl = 0, lrst_pin_n = 1, fgp = 0, tol = 0;
  int vld_lo = 0, commits = 0;
  logic [31:0] bcrc [4], bprev [4];
  logic [7:0] rows [6];
  int fails = 0, compares = 0, n = 0, sk = 0, slots = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  initial begin
    #1.7;
    forever #24 link_clk = ~link_clk;
  end
  plcu_top #(.LANES(4), .TO_SHORT(16'h0010), .TO_LONG(16'h0020)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .link_clk(link_clk),
    .tx_in_dat(tx_in_dat), .tx_in_ctrl(tx_in_ctrl),
    .tx_in_start(tx_in_start), .tx_in_ready(tx_in_ready),
    .tx_command_address_data_lines(tx_cad), .tx_link_control_line(tx_ctl),
    .rx_command_address_data_lines(rx_cad), .rx_link_control_line(rx_ctl),
    .rx_start(rx_start), .rx_out_dat(rx_out_dat), .rx_out_ctrl(rx_out_ctrl),
    .rx_out_vld(rx_out_vld), .rx_commit(rx_commit),
    .link_reset_pin_n(lrst_pin_n), .first_generation_protocol(fgp),
    .control_deassert_timeout_long(tol), .enter_reset(enter_reset),
    .warm_rst(warm_rst), .map_flood(map_flood), .map_fatal(map_fatal),
    .map_nonfatal(map_nonfatal), .link_control_register_crc_clr(crc_clr),
    .proto_err_clr(proto_clr), .link_control_register_crc_err(crc_err),
    .proto_err_log(proto_log), .ovf_err_log(ovf_log),
    .sync_flood_req(flood_req), .fatal_irq(fatal_irq), .nonfatal_irq(nf_irq));
  plcu_peer peer (.link_clk(link_clk), .arst_n(arst_n), .tx_cad(tx_cad),
    .tx_ctl(tx_ctl), .tx_start(tx_in_start), .bad_lane(bad_lane),
    .rx_cad(rx_cad), .rx_ctl(rx_ctl), .rx_start(rx_start));
  // -------------------------------------------------------------------
  // reference crc, one bit-time of nine bits
  // -------------------------------------------------------------------
  function automatic logic [31:0] ref9(logic [31:0] c, logic [8:0] m);
    logic t;
    for (int i = 0; i < 9; i++) begin
      t = c[31];
      c = {c[30:0], m[i]};
      if (t) begin
        c = c ^ 32'h04c11db7;
      end
    end
    return c;
  endfunction : ref9
  task automatic tally_and_finish;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  // -------------------------------------------------------------------
  // link side source: data changes only after it was taken
  // -------------------------------------------------------------------
  always @(negedge link_clk) begin
    if (run) begin
      `CHK({rx_out_ctrl, rx_out_dat}, {pctl, pcad}, "rx pass")
      vld_lo += !rx_out_vld;
      commits += rx_commit;
    end
    pcad = rx_cad;
    pctl = rx_ctl;
    if (sl_pend) begin
      for (int l = 0; l < 4; l++) begin
        `CHK(tx_cad[8*l+:8], ~bprev[l][8*sk+:8], "crc byte")
      end
      `CHK(tx_ctl, 1'b1, "crc control")
      sk = (sk + 1) % 4;
      slots++;
    end
    sl_pend = run && !tx_in_ready && !enter_reset;
    tx_in_start <= go && !run;
    if (go && !run) begin
      run = 1;
      for (int l = 0; l < 4; l++) begin
        bcrc[l] = 32'hffffffff;
      end
    end
    bad_lane <= (n == 700) ? 4'h4 : 4'h0;
    if (run && tx_in_ready) begin
      tx_in_dat <= {4{n[7:0]}} ^ pat;
      tx_in_ctrl <= !(n >= 1200 && n < 1240);
      for (int l = 0; l < 4; l++) begin
        bcrc[l] = ref9(bcrc[l], {(l == 0) ? !(n >= 1200 && n < 1240) : 1'b0,
          n[7:0] ^ pat[8*l+:8]});
      end
      n++;
      if (n % 512 == 0) begin
        for (int l = 0; l < 4; l++) begin
          bprev[l] = bcrc[l];
          bcrc[l] = 32'hffffffff;
        end
      end
    end
  end
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    // rows: warm, flood, fatal, nonfatal, then expected three outputs
    rows = '{8'h00, 8'h48, 8'h24, 8'h12, 8'h7e, 8'hf0};
    repeat (2) @(negedge link_clk);
    `CHK(tx_in_ready, 1'b0, "ready in reset")
    `CHK(crc_err, 4'h0, "log in reset")
    arst_n = 1;
    repeat (6) @(negedge link_clk);
    go = 1;
    wait (slots == 4);
    repeat (30) @(negedge link_clk);
    `CHK(crc_err, 4'h0, "clean link logged")
    wait (slots == 8);
    repeat (30) @(negedge link_clk);
    `CHK(crc_err, 4'h4, "lane error bit")
    `CHK(vld_lo, 8, "rx crc slots")
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk);
      {warm_rst, map_flood, map_fatal, map_nonfatal} = rows[i][7:4];
      repeat (3) @(negedge core_clk);
      `CHK({flood_req, fatal_irq, nf_irq}, rows[i][3:1], "mapping")
      `CHK(crc_err, 4'h4, "log kept")
    end
    warm_rst = 0;
    crc_clr = 4'h4;
    @(negedge core_clk);
    crc_clr = 4'h0;
    repeat (2) @(negedge core_clk);
    `CHK(crc_err, 4'h0, "write one clear")
    wait (n >= 1280);
    repeat (10) @(negedge link_clk);
    `CHK(proto_log, 1'b1, "control timeout")
    `CHK(commits, 1, "commit after control")
    @(negedge core_clk);
    proto_clr = 1;
    @(negedge core_clk);
    proto_clr = 0;
    repeat (2) @(negedge core_clk);
    `CHK(proto_log, 1'b0, "protocol clear")
    `CHK(ovf_log, 1'b0, "unused log")
    enter_reset = 1;
    repeat (8) @(negedge link_clk);
    `CHK({tx_ctl, tx_cad}, {1'b0, 32'hffffffff}, "reset signalling")
    `CHK(tx_in_ready, 1'b0, "ready in reset signalling")
    tally_and_finish();
  end
endmodule : test_plcu_top
